// [pkg/intc_pkg.sv]
// constants, carriers and helpers shared by the three-source interrupt controller
// assumes one 100 MHz clock and a core that reports instruction boundaries
package intc_pkg;

    // register port geometry and program counter width
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam int          PC_W            = 12;

    // register offsets
    localparam logic [3:0]  REG_REQUEST     = 4'h0;
    localparam logic [3:0]  REG_ENABLE      = 4'h1;
    localparam logic [3:0]  REG_CONFIG      = 4'h2;
    localparam logic [3:0]  REG_STATUS      = 4'h3;

    // bit positions of the three sources inside request and enable registers
    localparam int          SRC_N           = 3;
    localparam int          BIT_TIMER8      = 0;
    localparam int          BIT_EXT         = 1;
    localparam int          BIT_INTERVAL    = 2;

    // config and status fields
    localparam int          CFG_EDGE_BIT    = 0;
    localparam int          STAT_LEVEL_BIT  = 0;
    localparam int          STAT_DEPTH_LSB  = 1;

    // reset values
    localparam logic [SRC_N-1:0] REQ_RESET  = 3'h0;
    localparam logic [SRC_N-1:0] EN_RESET   = 3'h0;

    // fixed vector addresses
    localparam logic [PC_W-1:0] VEC_TIMER8   = 12'h003;
    localparam logic [PC_W-1:0] VEC_EXT      = 12'h002;
    localparam logic [PC_W-1:0] VEC_INTERVAL = 12'h001;
    localparam logic [PC_W-1:0] VEC_NONE     = 12'h000;

    // hardware status stack
    localparam logic [1:0]  STACK_DEPTH     = 2'h3;
    localparam logic [1:0]  DEPTH_EMPTY     = 2'h0;
    localparam logic [1:0]  DEPTH_STEP      = 2'h1;

    typedef enum logic [1:0] {
        SRC_NONE     = 2'b00,
        SRC_INTERVAL = 2'b01,
        SRC_EXT      = 2'b10,
        SRC_TIMER8   = 2'b11
    } src_e;

    // status flags saved on acceptance
    typedef struct packed {
        logic decimal_mode;
        logic compare_flag;
        logic carry;
        logic zero;
        logic index_mode_flag;
    } status_flags_s;

    // one report from the instruction sequencer
    typedef struct packed {
        logic boundary;              // an instruction cycle ends this clock
        logic first_of_two;          // that cycle is the first of a two-cycle instruction
        logic accept_enable_instr;   // the ending instruction is the enable instruction
        logic accept_block_instr;    // the ending instruction is the disable instruction
        logic return_from_service_instr;
    } core_step_s;

    function automatic logic [PC_W-1:0] vector_of(input src_e src);
        case (src)
            SRC_TIMER8:   vector_of = VEC_TIMER8;
            SRC_EXT:      vector_of = VEC_EXT;
            SRC_INTERVAL: vector_of = VEC_INTERVAL;
            default:      vector_of = VEC_NONE;
        endcase
    endfunction : vector_of

    function automatic logic [SRC_N-1:0] onehot_of(input src_e src);
        case (src)
            SRC_TIMER8:   onehot_of = 3'h1 << BIT_TIMER8;
            SRC_EXT:      onehot_of = 3'h1 << BIT_EXT;
            SRC_INTERVAL: onehot_of = 3'h1 << BIT_INTERVAL;
            default:      onehot_of = 3'h0;
        endcase
    endfunction : onehot_of

endpackage : intc_pkg

// [rtl/ext_edge_detect.sv]
// edge detector and level flag for the external request line
// assumes the pin is already synchronous to clk
`timescale 1ns/100ps
module ext_edge_detect (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // pin and selection
    input  wire logic pin,
    input  wire logic edge_select_flag,
    // results
    output logic      level_reg,
    output logic      edge_pulse
);
    logic prev_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_reg  <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            prev_reg  <= pin;
            level_reg <= pin; // see [R15]
        end
    end

    // 0 takes rising, 1 takes falling
    always_comb begin
        if (edge_select_flag) begin
            edge_pulse = prev_reg & ~pin; // see [R17]
        end else begin
            edge_pulse = ~prev_reg & pin; // see [R13]
        end
    end

    property p_edge_falling;
        @(posedge clk) disable iff (reset)
        (edge_select_flag && $fell(pin)) |-> edge_pulse;
    endproperty
    a_edge_falling: assert property (p_edge_falling) // see [R16]
        else $error("falling edge missed");
endmodule : ext_edge_detect

// [rtl/three_source_interrupt_ctrl.sv]
// three-source interrupt controller: request and enable flags, global accept
// enable, fixed priority and vectors, hardware status stack
// assumes the core reports each instruction boundary on core_step and applies
// the vector and restored flags that this block presents
`timescale 1ns/100ps

// Function
// [R1] accept jumps to vector 003h timer8, 002h external, 001h interval timer
// [R2] simultaneous requests taken one at a time: timer8, external, interval
// [R3] nothing accepted unless the global accept enable is set
// [R4] enable instruction sets the global accept enable
// [R5] disable instruction and each acceptance clear the global accept enable
// [R6] a new enable acts only after the following instruction completes
// [R7] acceptance pushes five status flags on a three-deep hardware stack
// [R8] service code saves data buffer and window register itself
// [R9] request flag set by its source, cleared when serviced
// [R10] each request has its own enable; taken only while enable is 1
// [R11] global accept enable is not readable by software
// [R12] reset clears the global accept enable
// [R13] external request set on the selected pin edge
// [R14] timer8 and interval timer requests come from their timers
// [R15] readable level flag mirrors the external pin
// [R16] external source can use rising or falling edges
// [R17] edge select 0 rising, 1 falling
// [R18] software may write request flags: 1 raises, 0 cancels
// [R19] service starts after the instruction ends; two-cycle ones after cycle two
// [R20] lower priority stays pending while higher is serviced
// [R21] hardware set beats the acceptance clear in the same cycle
// [R22] accept only with global enable, source enable and request all set
module three_source_interrupt_ctrl (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset,
    // register port
    input  wire logic [intc_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [intc_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [intc_pkg::DATA_W-1:0]    reg_rdata,
    // instruction sequencer
    input  wire intc_pkg::core_step_s           core_step,
    input  wire intc_pkg::status_flags_s        core_flags,
    output logic                                accept_pulse,
    output logic      [intc_pkg::PC_W-1:0]      accept_vector,
    output logic                                restore_valid,
    output intc_pkg::status_flags_s             restore_flags,
    // request sources
    input  wire logic                           timer8_irq,
    input  wire logic                           interval_irq,
    input  wire logic                           ext_line_pin
);
    import intc_pkg::*;

    logic [SRC_N-1:0]   request_reg;
    logic [SRC_N-1:0]   request_next;
    logic [SRC_N-1:0]   enable_reg;
    logic               edge_select_flag;
    logic               global_enable_reg;
    logic [1:0]         depth_reg;
    status_flags_s      stack_mem [STACK_DEPTH];

    logic               ext_level;
    logic               ext_edge;
    logic [SRC_N-1:0]   hw_set;
    logic [SRC_N-1:0]   effective;
    src_e               winner;
    logic               take_point;
    logic               stack_full;
    logic               fire;
    logic               pop;
    logic               wr_request;
    logic [SRC_N-1:0]   win_onehot;

    logic [DATA_W-1:0]  rdata_reg;
    logic               accept_reg;
    logic [PC_W-1:0]    vector_reg;
    logic               restore_valid_reg;
    status_flags_s      restore_flags_reg;

    ext_edge_detect ext_edge_detect_inst (
        .clk              (clk),
        .reset            (reset),
        .pin              (ext_line_pin),
        .edge_select_flag (edge_select_flag),
        .level_reg        (ext_level),
        .edge_pulse       (ext_edge)
    );

    // hardware request sources
    always_comb begin
        hw_set               = '0;
        hw_set[BIT_TIMER8]   = timer8_irq;   // see [R14]
        hw_set[BIT_EXT]      = ext_edge;     // see [R13]
        hw_set[BIT_INTERVAL] = interval_irq; // see [R14]
    end

    assign effective = request_reg & enable_reg; // see [R10]

    // fixed priority; lower ones wait in request_reg until chosen
    always_comb begin
        if (effective[BIT_TIMER8]) begin
            winner = SRC_TIMER8; // see [R2]
        end else if (effective[BIT_EXT]) begin
            winner = SRC_EXT;
        end else if (effective[BIT_INTERVAL]) begin
            winner = SRC_INTERVAL; // see [R20]
        end else begin
            winner = SRC_NONE;
        end
    end

    // only the last cycle of an instruction is a legal point to branch
    assign take_point = core_step.boundary & ~core_step.first_of_two; // see [R19]
    assign stack_full = (depth_reg == STACK_DEPTH);

    // a return or disable ending now wins over a new acceptance at the same boundary;
    // acceptance with a full stack waits so saved flags are never overwritten
    assign fire = take_point & global_enable_reg & (winner != SRC_NONE) // see [R22]
                & ~stack_full
                & ~core_step.accept_block_instr
                & ~core_step.return_from_service_instr; // see [R3]
    assign pop  = take_point & core_step.return_from_service_instr & (depth_reg != DEPTH_EMPTY);
    assign wr_request = reg_wr & (reg_addr == REG_REQUEST);
    // named vector, since a bit select on a call result is not portable
    assign win_onehot = onehot_of(winner);

    // request flags: hardware set, then software write, then acceptance clear
    always_comb begin
        for (int i = 0; i < SRC_N; i++) begin
            if (hw_set[i]) begin
                request_next[i] = 1'b1; // see [R21]
            end else if (wr_request) begin
                request_next[i] = reg_wdata[i]; // see [R18]
            end else if (fire && win_onehot[i]) begin
                request_next[i] = 1'b0; // see [R9]
            end else begin
                request_next[i] = request_reg[i];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            request_reg <= REQ_RESET;
        end else begin
            request_reg <= request_next;
        end
    end

    // software-owned configuration
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable_reg       <= EN_RESET;
            edge_select_flag <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == REG_ENABLE) begin
                enable_reg <= reg_wdata[SRC_N-1:0];
            end
            if (reg_addr == REG_CONFIG) begin
                edge_select_flag <= reg_wdata[CFG_EDGE_BIT]; // see [R17]
            end
        end
    end

    // global accept enable; set only at the enable instruction's last cycle, so
    // the earliest branch is at the end of the instruction after it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            global_enable_reg <= 1'b0; // see [R12]
        end else if (fire) begin
            global_enable_reg <= 1'b0; // see [R5]
        end else if (take_point && core_step.accept_block_instr) begin
            global_enable_reg <= 1'b0; // see [R5]
        end else if (take_point && core_step.accept_enable_instr) begin
            global_enable_reg <= 1'b1; // see [R4] [R6]
        end
    end

    // hardware status stack; data buffer and window register are left to software
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            depth_reg <= DEPTH_EMPTY;
        end else if (fire) begin
            depth_reg <= depth_reg + DEPTH_STEP; // see [R7]
        end else if (pop) begin
            depth_reg <= depth_reg - DEPTH_STEP;
        end
    end

    always_ff @(posedge clk) begin
        if (fire) begin
            stack_mem[depth_reg] <= core_flags; // see [R7]
        end
    end

    // answers to the core
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            accept_reg <= 1'b0;
            vector_reg <= VEC_NONE;
        end else begin
            accept_reg <= fire;
            if (fire) begin
                vector_reg <= vector_of(winner); // see [R1]
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            restore_valid_reg <= 1'b0;
            restore_flags_reg <= '0;
        end else begin
            restore_valid_reg <= pop;
            if (pop) begin
                restore_flags_reg <= stack_mem[depth_reg - DEPTH_STEP];
            end
        end
    end

    // read data for one cycle after the strobe; global enable has no address
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_REQUEST: rdata_reg <= DATA_W'(request_reg);
                REG_ENABLE:  rdata_reg <= DATA_W'(enable_reg);
                REG_CONFIG:  rdata_reg <= DATA_W'(edge_select_flag) << CFG_EDGE_BIT;
                REG_STATUS:  rdata_reg <= (DATA_W'(depth_reg) << STAT_DEPTH_LSB)
                                        | (DATA_W'(ext_level) << STAT_LEVEL_BIT); // see [R15]
                default:     rdata_reg <= '0; // see [R11]
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata     = rdata_reg;
    assign accept_pulse  = accept_reg;
    assign accept_vector = vector_reg;
    assign restore_valid = restore_valid_reg;
    assign restore_flags = restore_flags_reg;

    property p_vector_timer8;
        @(posedge clk) disable iff (reset)
        (fire && effective[BIT_TIMER8]) |=> (accept_pulse && accept_vector == VEC_TIMER8);
    endproperty
    a_vector_timer8: assert property (p_vector_timer8) // see [R1]
        else $error("timer8 accept vector wrong");

    property p_priority;
        @(posedge clk) disable iff (reset)
        (accept_pulse && accept_vector == VEC_INTERVAL)
            |-> !$past(effective[BIT_TIMER8] || effective[BIT_EXT]);
    endproperty
    a_priority: assert property (p_priority) // see [R2]
        else $error("interval timer taken over higher priority");

    property p_needs_global;
        @(posedge clk) disable iff (reset)
        accept_pulse |-> $past(global_enable_reg);
    endproperty
    a_needs_global: assert property (p_needs_global) // see [R3]
        else $error("accept without global enable");

    property p_enable_sets;
        @(posedge clk) disable iff (reset)
        (take_point && core_step.accept_enable_instr && !core_step.accept_block_instr && !fire)
            |=> global_enable_reg;
    endproperty
    a_enable_sets: assert property (p_enable_sets) // see [R4]
        else $error("enable instruction did not set global enable");

    property p_accept_clears;
        @(posedge clk) disable iff (reset)
        accept_pulse |-> (!global_enable_reg && !fire);
    endproperty
    a_accept_clears: assert property (p_accept_clears) // see [R5]
        else $error("global enable still set after accept");

    property p_no_accept_after_ei;
        @(posedge clk) disable iff (reset)
        (take_point && core_step.accept_enable_instr && !$past(global_enable_reg, 1)
            && !global_enable_reg) |-> !fire;
    endproperty
    a_no_accept_after_ei: assert property (p_no_accept_after_ei) // see [R6]
        else $error("accept at the enable instruction boundary");

    // global enable may change only where an instruction really ends
    property p_enable_at_end;
        @(posedge clk) disable iff (reset)
        !take_point |=> $stable(global_enable_reg);
    endproperty
    a_enable_at_end: assert property (p_enable_at_end) // see [R6]
        else $error("global enable changed inside an instruction");

    property p_push;
        @(posedge clk) disable iff (reset)
        fire |=> (depth_reg == $past(depth_reg) + DEPTH_STEP);
    endproperty
    a_push: assert property (p_push) // see [R7]
        else $error("stack depth did not grow on accept");

    property p_serviced_clear;
        @(posedge clk) disable iff (reset)
        (fire && winner == SRC_INTERVAL && !hw_set[BIT_INTERVAL] && !wr_request)
            |=> !request_reg[BIT_INTERVAL];
    endproperty
    a_serviced_clear: assert property (p_serviced_clear) // see [R9]
        else $error("request flag not cleared on service");

    property p_source_enable;
        @(posedge clk) disable iff (reset)
        fire |-> |(onehot_of(winner) & enable_reg & request_reg);
    endproperty
    a_source_enable: assert property (p_source_enable) // see [R10]
        else $error("accepted a masked source");

    property p_boundary_only;
        @(posedge clk) disable iff (reset)
        accept_pulse |-> $past(core_step.boundary && !core_step.first_of_two);
    endproperty
    a_boundary_only: assert property (p_boundary_only) // see [R19]
        else $error("accept inside an instruction");

    property p_set_wins;
        @(posedge clk) disable iff (reset)
        (fire && winner == SRC_TIMER8 && timer8_irq) |=> request_reg[BIT_TIMER8];
    endproperty
    a_set_wins: assert property (p_set_wins) // see [R21]
        else $error("new timer8 request lost on accept");

    property p_ext_edge;
        @(posedge clk) disable iff (reset)
        ext_edge |=> request_reg[BIT_EXT];
    endproperty
    a_ext_edge: assert property (p_ext_edge) // see [R13]
        else $error("external edge did not set request");

    property p_level;
        @(posedge clk) disable iff (reset)
        ##1 (ext_level == $past(ext_line_pin));
    endproperty
    a_level: assert property (p_level) // see [R15]
        else $error("level flag does not follow pin");
endmodule : three_source_interrupt_ctrl

// [verif/core_model.sv]
// far-side model: instruction sequencer plus the three request sources
// assumes the controller samples everything on the rising edge of clk
`timescale 1ns/100ps
module core_model (
    // clock
    input  wire logic                           clk,
    // towards the controller
    output intc_pkg::core_step_s                core_step,
    output intc_pkg::status_flags_s             core_flags,
    output logic                                timer8_irq,
    output logic                                interval_irq,
    output logic                                ext_line_pin,
    // from the controller
    input  wire logic                           accept_pulse,
    input  wire logic      [intc_pkg::PC_W-1:0] accept_vector,
    input  wire logic                           restore_valid,
    input  wire intc_pkg::status_flags_s        restore_flags
);
    import intc_pkg::*;
    int             accepts;
    int             restores;
    int             last_gap;
    int             since;
    logic [PC_W-1:0] last_vec;
    status_flags_s  last_restore;
    logic [3:0]     data_buffer_reg;
    logic [3:0]     saved_buffer;

    initial begin
        core_step = '0;
        core_flags = '0;
        timer8_irq = 1'b0;
        interval_irq = 1'b0;
        ext_line_pin = 1'b0;
        accepts = 0;
        restores = 0;
        since = 0;
        data_buffer_reg = 4'h5;
    end

    // gap counts edges from the last boundary, to catch an early accept
    always @(posedge clk) begin
        if (accept_pulse === 1'b1) begin
            accepts++;
            last_vec = accept_vector;
            last_gap = since + 1;
            saved_buffer = data_buffer_reg;
        end
        if (restore_valid === 1'b1) begin
            restores++;
            last_restore = restore_flags;
            data_buffer_reg = saved_buffer;
        end
        since = (core_step.boundary === 1'b1) ? 0 : since + 1;
    end

    // kind: 0 plain, 1 enable, 2 disable, 3 return, 4 two-cycle plain
    task automatic instr(input int kind, input logic coinc, input status_flags_s f);
        @(posedge clk);
        core_flags <= f;
        if (kind == 4) begin
            core_step <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            @(posedge clk);
        end
        core_step  <= '{1'b1, 1'b0, kind == 1, kind == 2, kind == 3};
        timer8_irq <= coinc;
        @(posedge clk);
        core_step  <= '0;
        timer8_irq <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : instr

    task automatic pulse(input int src);
        @(posedge clk);
        timer8_irq   <= (src == 0);
        interval_irq <= (src != 0);
        @(posedge clk);
        timer8_irq   <= 1'b0;
        interval_irq <= 1'b0;
    endtask : pulse

    task automatic set_pin(input logic v);
        @(posedge clk);
        ext_line_pin <= v;
        repeat (2) @(posedge clk);
    endtask : set_pin
endmodule : core_model

// [verif/tb_top.sv]
// testbench for the three-source interrupt controller
// assumes core_model drives the sequencer and source side
`timescale 1ns/100ps
module tb_top;
    import intc_pkg::*;
    localparam status_flags_s fa = 5'h15;
    localparam status_flags_s fb = 5'h0a;
    logic                 clk;
    logic                 reset;
    logic [ADDR_W-1:0]    reg_addr;
    logic [DATA_W-1:0]    reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [DATA_W-1:0]    reg_rdata;
    core_step_s           core_step;
    status_flags_s        core_flags;
    status_flags_s        restore_flags;
    logic                 accept_pulse;
    logic                 restore_valid;
    logic [PC_W-1:0]      accept_vector;
    logic                 timer8_irq;
    logic                 interval_irq;
    logic                 ext_line_pin;
    logic [PC_W-1:0]      vecs [3] = '{VEC_TIMER8, VEC_EXT, VEC_INTERVAL};
    status_flags_s        stack[$];
    int                   failures = 0;
    int                   comparisons = 0;
    int                   na = 0;
    int                   nr = 0;

    three_source_interrupt_ctrl three_source_interrupt_ctrl_inst (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .core_step(core_step), .core_flags(core_flags), .accept_pulse(accept_pulse),
        .accept_vector(accept_vector), .restore_valid(restore_valid),
        .restore_flags(restore_flags), .timer8_irq(timer8_irq),
        .interval_irq(interval_irq), .ext_line_pin(ext_line_pin));

    core_model core_model_inst (
        .clk(clk), .core_step(core_step), .core_flags(core_flags),
        .timer8_irq(timer8_irq), .interval_irq(interval_irq),
        .ext_line_pin(ext_line_pin), .accept_pulse(accept_pulse),
        .accept_vector(accept_vector), .restore_valid(restore_valid),
        .restore_flags(restore_flags));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(16'(reg_rdata), 16'(exp), "read data");
    endtask : rd

    task automatic run(input int kind, input logic coinc, input status_flags_s f);
        core_model_inst.instr(kind, coinc, f);
    endtask : run

    task automatic acc(input logic [PC_W-1:0] vec, input status_flags_s f);
        na++;
        stack.push_back(f);
        chk(16'(core_model_inst.accepts), 16'(na), "accept count");
        chk(16'(core_model_inst.last_vec), 16'(vec), "vector");
        chk(16'(core_model_inst.last_gap), 16'h1, "accept delay");
    endtask : acc

    task automatic none;
        chk(16'(core_model_inst.accepts), 16'(na), "unexpected accept");
    endtask : none

    task automatic ret;
        status_flags_s f;
        f = stack.pop_back();
        nr++;
        chk(16'(core_model_inst.restores), 16'(nr), "restore count");
        chk(16'(core_model_inst.last_restore), 16'(f), "restored flags");
    endtask : ret

    initial begin
        reset = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) rd(4'(i), 8'h00);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        wr(REG_STATUS, 8'hff);
        rd(REG_STATUS, 8'h00);
        wr(REG_REQUEST, 8'h07);
        rd(REG_REQUEST, 8'h07);
        wr(REG_REQUEST, 8'h00);
        rd(REG_REQUEST, 8'h00);
        wr(REG_ENABLE, 8'h07);
        rd(REG_ENABLE, 8'h07);
        core_model_inst.pulse(0);
        rd(REG_REQUEST, 8'h01);
        run(0, 1'b0, fa);
        none();
        wr(REG_ENABLE, 8'h00);
        run(1, 1'b0, fa);
        run(0, 1'b0, fa);
        none();
        wr(REG_ENABLE, 8'h07);
        run(0, 1'b0, fa);
        acc(VEC_TIMER8, fa);
        rd(REG_REQUEST, 8'h00);
        core_model_inst.pulse(1);
        run(0, 1'b0, fa);
        none();
        run(1, 1'b0, fa);
        run(2, 1'b0, fa);
        run(0, 1'b0, fa);
        none();
        run(1, 1'b0, fa);
        run(4, 1'b0, fb);
        acc(VEC_INTERVAL, fb);
        rd(REG_STATUS, 8'h04);
        wr(REG_REQUEST, 8'h07);
        // a return right after the enable must not let a request in
        for (int i = 0; i < 3; i++) begin
            run(1, 1'b0, fa);
            run(3, 1'b0, fa);
            none();
            ret();
            run(0, 1'b0, status_flags_s'(5'(i + 3)));
            acc(vecs[i], status_flags_s'(5'(i + 3)));
        end
        wr(REG_REQUEST, 8'h01);
        run(1, 1'b0, fa);
        run(0, 1'b0, fb);
        acc(VEC_TIMER8, fb);
        rd(REG_STATUS, 8'h06);
        wr(REG_REQUEST, 8'h01);
        run(1, 1'b0, fa);
        run(0, 1'b0, fa);
        none();
        run(3, 1'b0, fa);
        ret();
        run(0, 1'b0, fa);
        acc(VEC_TIMER8, fa);
        core_model_inst.set_pin(1'b1);
        rd(REG_REQUEST, 8'h02);
        rd(REG_STATUS, 8'h07);
        wr(REG_REQUEST, 8'h00);
        core_model_inst.set_pin(1'b0);
        rd(REG_REQUEST, 8'h00);
        rd(REG_STATUS, 8'h06);
        wr(REG_CONFIG, 8'h01);
        rd(REG_CONFIG, 8'h01);
        core_model_inst.set_pin(1'b1);
        rd(REG_REQUEST, 8'h00);
        core_model_inst.set_pin(1'b0);
        rd(REG_REQUEST, 8'h02);
        run(3, 1'b0, fa);
        ret();
        wr(REG_ENABLE, 8'h01);
        wr(REG_REQUEST, 8'h03);
        run(1, 1'b0, fa);
        run(0, 1'b1, fb);
        acc(VEC_TIMER8, fb);
        rd(REG_REQUEST, 8'h03);
        wrap_up();
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        wrap_up();
    end
endmodule : tb_top
